// [src/status_event_pkg.sv]
// Constants for the status and event reporting block
package status_event_pkg;
	localparam int SE_OPC = 0;
	localparam int SE_QYE = 2;
	localparam int SE_DDE = 3;
	localparam int SE_EXE = 4;
	localparam int SE_CME = 5;
	localparam int SE_PON = 7;
	localparam logic [7:0] SE_USED = 8'hBD;
	localparam int QD_VOLT = 0;
	localparam int QD_CURR = 1;
	localparam int QD_OHMS = 9;
	localparam int QD_LOLIM = 11;
	localparam int QD_HILIM = 12;
	localparam logic [15:0] QD_USED = 16'h1A03;
	localparam int SB_QUES = 3;
	localparam int SB_MAV = 4;
	localparam int SB_ESB = 5;
	localparam int SB_RQS = 6;
	localparam logic [7:0] SB_EN_USED = 8'h38;
	localparam logic [1:0] OVL_VOLT = 2'h0;
	localparam logic [1:0] OVL_CURR = 2'h1;
	localparam logic [1:0] OVL_OHMS = 2'h2;
endpackage

// [src/status_event_reporting.sv]
// Status byte, standard event and questionable data reporting
`timescale 1ns/1ps
module status_event_reporting
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Power-on indication and stored power-on clear setting
	input wire logic power_on_i,
	input wire logic psc_i,
	// Event sources
	input wire logic opc_cmd_i,
	input wire logic prior_done_i,
	input wire logic err_query_empty_i,
	input wire logic err_query_interrupted_i,
	input wire logic err_query_deadlock_i,
	input wire logic err_device_i,
	input wire logic err_exec_i,
	input wire logic err_command_i,
	input wire logic overload_i,
	input wire logic [1:0] overload_kind_i,
	input wire logic limit_low_i,
	input wire logic limit_high_i,
	// Output buffer state
	input wire logic out_buf_nonempty_i,
	input wire logic fetch_mode_i,
	input wire logic meas_done_i,
	// Command-decoded strobes
	input wire logic cls_i,
	input wire logic preset_i,
	input wire logic sre_wr_i,
	input wire logic ese_wr_i,
	input wire logic qen_wr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [15:0] qen_wr_data_i,
	input wire logic esr_rd_i,
	input wire logic qev_rd_i,
	input wire logic stb_query_i,
	// Serial poll
	input wire logic serial_poll_i,
	// Outputs
	output logic srq_o,
	output logic [7:0] poll_byte_o,
	output logic stb_valid_o,
	output logic [7:0] stb_data_o,
	output logic [7:0] esr_data_o,
	output logic [15:0] qev_data_o,
	output logic [7:0] ese_o,
	output logic [7:0] sre_o,
	output logic [15:0] qen_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT} stbq_state_t;
	logic [7:0] ser_q;
	logic [15:0] qdr_q;
	logic [7:0] ese_q;
	logic [7:0] sre_q;
	logic [15:0] qen_q;
	logic rqs_q;
	logic mav_q;
	logic opc_pend_q;
	logic pon_q;
	logic stb_pend_q;
	stbq_state_t stbq_q;
	logic [7:0] ser_set;
	logic [15:0] qdr_set;
	logic ques_sum;
	logic esb_sum;
	logic rqs_src;
	logic [7:0] stb_now;

	function automatic logic masked_or16(input logic [15:0] ev, input logic [15:0] en);
		masked_or16 = |(ev & en);
	endfunction
	assign esb_sum = masked_or16({8'h00, ser_q}, {8'h00, ese_q});
	assign ques_sum = masked_or16(qdr_q, qen_q);
	assign rqs_src = masked_or16({8'h00, stb_now}, {8'h00, sre_q & status_event_pkg::SB_EN_USED});

	always_comb
	begin
		stb_now = 8'h00;
		stb_now[status_event_pkg::SB_QUES] = ques_sum;
		stb_now[status_event_pkg::SB_MAV] = mav_q;
		stb_now[status_event_pkg::SB_ESB] = esb_sum;
		stb_now[status_event_pkg::SB_RQS] = rqs_q;
	end

	always_comb
	begin
		ser_set = 8'h00;
		ser_set[status_event_pkg::SE_OPC] = opc_pend_q & prior_done_i;
		ser_set[status_event_pkg::SE_QYE] = err_query_empty_i | err_query_interrupted_i |
			err_query_deadlock_i;
		ser_set[status_event_pkg::SE_DDE] = err_device_i | overload_i;
		ser_set[status_event_pkg::SE_EXE] = err_exec_i;
		ser_set[status_event_pkg::SE_CME] = err_command_i;
		ser_set[status_event_pkg::SE_PON] = pon_q;
	end

	always_comb
	begin
		qdr_set = 16'h0000;
		qdr_set[status_event_pkg::QD_VOLT] = overload_i &
			(overload_kind_i == status_event_pkg::OVL_VOLT);
		qdr_set[status_event_pkg::QD_CURR] = overload_i &
			(overload_kind_i == status_event_pkg::OVL_CURR);
		qdr_set[status_event_pkg::QD_OHMS] = overload_i &
			(overload_kind_i == status_event_pkg::OVL_OHMS);
		qdr_set[status_event_pkg::QD_LOLIM] = limit_low_i;
		qdr_set[status_event_pkg::QD_HILIM] = limit_high_i;
	end

	// Power-on pulse is registered one cycle; reset clears it, so a pulse during reset is not seen
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			pon_q <= 1'b0;
		else
			pon_q <= power_on_i;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			opc_pend_q <= 1'b0;
		else if (opc_cmd_i)
			opc_pend_q <= 1'b1;
		else if (prior_done_i)
			opc_pend_q <= 1'b0;
	end

	// Latching standard events; set wins over clear
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			ser_q <= 8'h00;
		// Clear on status clear or query
		else if (cls_i | esr_rd_i)
			ser_q <= ser_set & status_event_pkg::SE_USED;
		else
			ser_q <= (ser_q | ser_set) & status_event_pkg::SE_USED;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			qdr_q <= 16'h0000;
		// Clear on status clear or event query
		else if (cls_i | qev_rd_i)
			qdr_q <= qdr_set & status_event_pkg::QD_USED;
		else
			qdr_q <= (qdr_q | qdr_set) & status_event_pkg::QD_USED;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			ese_q <= 8'h00;
		else if (ese_wr_i)
			ese_q <= wr_data_i;
		else if (power_on_i & psc_i)
			ese_q <= 8'h00;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			sre_q <= 8'h00;
		else if (sre_wr_i)
			sre_q <= wr_data_i;
		else if (power_on_i & psc_i)
			sre_q <= 8'h00;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			qen_q <= 16'h0000;
		else if (power_on_i | preset_i)
			qen_q <= 16'h0000;
		else if (qen_wr_i)
			qen_q <= qen_wr_data_i;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			mav_q <= 1'b0;
		else
			mav_q <= out_buf_nonempty_i & (~fetch_mode_i | meas_done_i);
	end

	// Request service; a new rising source re-arms it
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			rqs_q <= 1'b0;
		else if (!rqs_src)
			rqs_q <= 1'b0;
		else if (serial_poll_i)
			rqs_q <= 1'b0;
		else if (!rqs_q && !stb_pend_q)
			rqs_q <= 1'b1;
	end

	// Latched poll so a poll clears until summary rises again
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			stb_pend_q <= 1'b0;
		else if (!rqs_src)
			stb_pend_q <= 1'b0;
		else if (serial_poll_i)
			stb_pend_q <= 1'b1;
	end

	assign srq_o = rqs_q;
	assign poll_byte_o = stb_now;

	// Status query waits for prior commands
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			stbq_q <= ST_IDLE;
			stb_valid_o <= 1'b0;
			stb_data_o <= 8'h00;
		end
		else
		begin
			stb_valid_o <= 1'b0;
			case (stbq_q)
				ST_IDLE:
					if (stb_query_i)
						stbq_q <= ST_WAIT;
				ST_WAIT:
					if (prior_done_i)
					begin
						stb_valid_o <= 1'b1;
						stb_data_o <= stb_now;
						stbq_q <= ST_IDLE;
					end
				default:
					stbq_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			esr_data_o <= 8'h00;
			qev_data_o <= 16'h0000;
		end
		else
		begin
			if (esr_rd_i)
				esr_data_o <= ser_q;
			if (qev_rd_i)
				qev_data_o <= qdr_q;
		end
	end

	assign ese_o = ese_q;
	assign sre_o = sre_q;
	assign qen_o = qen_q;

	property p_srq_follows;
		@(posedge clock_i) disable iff (rst_i)
		$rose(rqs_src) && !serial_poll_i |=> srq_o;
	endproperty
	a_srq_follows: assert property (p_srq_follows) else $error("srq not raised");
	property p_no_rqs_unmasked;
		@(posedge clock_i) disable iff (rst_i)
		(sre_q == 8'h00) |=> !srq_o;
	endproperty
	a_no_rqs_unmasked: assert property (p_no_rqs_unmasked) else $error("srq unmasked");
	property p_poll_clears;
		@(posedge clock_i) disable iff (rst_i)
		serial_poll_i |=> !rqs_q;
	endproperty
	a_poll_clears: assert property (p_poll_clears) else $error("poll no clear");
	property p_poll_keeps_others;
		@(posedge clock_i) disable iff (rst_i)
		serial_poll_i && !cls_i && !esr_rd_i && !qev_rd_i && !sre_wr_i |=>
			(ser_q & $past(ser_q)) == $past(ser_q);
	endproperty
	a_poll_keeps_others: assert property (p_poll_keeps_others) else $error("poll cleared");
	property p_stbq_keeps_rqs;
		@(posedge clock_i) disable iff (rst_i)
		stb_query_i && rqs_q && rqs_src && !serial_poll_i |=> rqs_q;
	endproperty
	a_stbq_keeps_rqs: assert property (p_stbq_keeps_rqs) else $error("query cleared rqs");
	property p_stbq_wait;
		@(posedge clock_i) disable iff (rst_i)
		stb_valid_o |-> $past(prior_done_i);
	endproperty
	a_stbq_wait: assert property (p_stbq_wait) else $error("early stb answer");
	property p_ser_reserved;
		@(posedge clock_i) disable iff (rst_i)
		(ser_q & ~status_event_pkg::SE_USED) == 8'h00;
	endproperty
	a_ser_reserved: assert property (p_ser_reserved) else $error("ser reserved set");
	property p_ser_latch;
		@(posedge clock_i) disable iff (rst_i)
		!cls_i && !esr_rd_i |=> (ser_q & $past(ser_q)) == $past(ser_q);
	endproperty
	a_ser_latch: assert property (p_ser_latch) else $error("event bit lost");
	property p_overload;
		@(posedge clock_i) disable iff (rst_i)
		overload_i |=> ser_q[status_event_pkg::SE_DDE];
	endproperty
	a_overload: assert property (p_overload) else $error("overload not flagged");
	property p_qdr_reserved;
		@(posedge clock_i) disable iff (rst_i)
		(qdr_q & ~status_event_pkg::QD_USED) == 16'h0000;
	endproperty
	a_qdr_reserved: assert property (p_qdr_reserved) else $error("qdr reserved set");
endmodule

// [testbench/bus_ctl_model.sv]
// Bus controller model that answers service requests with a serial poll
`timescale 1ns/1ps
module bus_ctl_model
(
	// Clock and bus lines
	input wire logic clock_i,
	input wire logic srq_i,
	input wire logic [7:0] poll_byte_i,
	// Control from the bench
	input wire logic auto_i,
	input wire logic [3:0] delay_i,
	// Poll results
	output logic serial_poll_o,
	output logic [7:0] status_o,
	output logic [7:0] polls_o
);
	logic busy_q;
	logic [3:0] cnt_q;
	initial
	begin
		serial_poll_o = 1'b0;
		status_o = 8'h00;
		polls_o = 8'h00;
		busy_q = 1'b0;
		cnt_q = 4'h0;
	end
	// Poll held one cycle, byte taken at the same edge
	always @(posedge clock_i)
		if (serial_poll_o)
		begin
			serial_poll_o <= 1'b0;
			status_o <= poll_byte_i;
			polls_o <= polls_o + 8'h01;
			busy_q <= 1'b0;
		end
		else if (busy_q && cnt_q == 4'h0)
			serial_poll_o <= 1'b1;
		else if (busy_q)
			cnt_q <= cnt_q - 4'h1;
		else if (auto_i && srq_i)
		begin
			busy_q <= 1'b1;
			cnt_q <= delay_i;
		end
endmodule

// [testbench/tb.sv]
// Self-checking bench for the status and event reporting block
`timescale 1ns/1ps
module tb;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic psc_i = 1'b0;
	logic prior_done_i = 1'b1;
	logic out_buf_nonempty_i = 1'b0;
	logic fetch_mode_i = 1'b0;
	logic meas_done_i = 1'b0;
	logic auto = 1'b0;
	logic [1:0] overload_kind_i = 2'h0;
	logic [7:0] wr_data_i = 8'h00;
	logic [15:0] qen_wr_data_i = 16'h0000;
	logic [18:0] p = '0;
	logic srq_o, stb_valid_o, serial_poll_i;
	logic [7:0] poll_byte_o, stb_data_o, esr_data_o, ese_o, sre_o, status, polls;
	logic [15:0] qev_data_o, qen_o;
	logic [7:0] sev [7] = '{8'h00, 8'h04, 8'h04, 8'h04, 8'h08, 8'h10, 8'h20};
	int mismatches = 0;
	int n_compared = 0;
	status_event_reporting DUT
	(
		.*,
		.opc_cmd_i(p[0]),
		.err_query_empty_i(p[1]),
		.err_query_interrupted_i(p[2]),
		.err_query_deadlock_i(p[3]),
		.err_device_i(p[4]),
		.err_exec_i(p[5]),
		.err_command_i(p[6]),
		.overload_i(p[7]),
		.limit_low_i(p[8]),
		.limit_high_i(p[9]),
		.cls_i(p[10]),
		.preset_i(p[11]),
		.sre_wr_i(p[12]),
		.ese_wr_i(p[13]),
		.qen_wr_i(p[14]),
		.esr_rd_i(p[15]),
		.qev_rd_i(p[16]),
		.stb_query_i(p[17]),
		.power_on_i(p[18])
	);
	bus_ctl_model ctl
	(
		.clock_i(clock_i),
		.srq_i(srq_o),
		.poll_byte_i(poll_byte_o),
		.auto_i(auto),
		.delay_i(4'h3),
		.serial_poll_o(serial_poll_i),
		.status_o(status),
		.polls_o(polls)
	);
	always #4 clock_i = ~clock_i;
	task summarize;
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk16(input logic [15:0] got, input logic [15:0] exp);
		chk8(got[15:8], exp[15:8]);
		chk8(got[7:0], exp[7:0]);
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task pulse(input int i);
		@(posedge clock_i);
		#1 p[i] = 1'b1;
		@(posedge clock_i);
		#1 p[i] = 1'b0;
	endtask
	task wr(input int i, input logic [15:0] d);
		wr_data_i = d[7:0];
		qen_wr_data_i = d;
		pulse(i);
	endtask
	task t_std;
		for (int i = 1; i < 7; i++)
		begin
			pulse(i);
			pulse(15);
			chk8(esr_data_o, sev[i]);
		end
		pulse(6);
		pulse(6);
		pulse(15);
		chk8(esr_data_o, 8'h20);
		pulse(15);
		chk8(esr_data_o, 8'h00);
		prior_done_i = 1'b0;
		pulse(0);
		cyc(3);
		pulse(15);
		chk8(esr_data_o, 8'h00);
		prior_done_i = 1'b1;
		cyc(2);
		pulse(15);
		chk8(esr_data_o, 8'h01);
	endtask
	task t_ques;
		for (int k = 0; k < 3; k++)
		begin
			overload_kind_i = 2'(k);
			pulse(7);
		end
		pulse(8);
		pulse(9);
		pulse(16);
		chk16(qev_data_o, 16'h1A03);
		pulse(15);
		chk8(esr_data_o, 8'h08);
		pulse(16);
		chk16(qev_data_o, 16'h0000);
	endtask
	task t_srq;
		wr(13, 16'h0010);
		pulse(5);
		cyc(2);
		chk8(poll_byte_o, 8'h20);
		chk8({7'h00, srq_o}, 8'h00);
		wr(12, 16'h0020);
		chk8(sre_o, 8'h20);
		pulse(15);
		pulse(5);
		cyc(1);
		chk8({7'h00, srq_o}, 8'h01);
		chk8(poll_byte_o, 8'h60);
		pulse(17);
		cyc(1);
		chk8({7'h00, stb_valid_o}, 8'h01);
		chk8(stb_data_o, 8'h60);
		chk8({7'h00, srq_o}, 8'h01);
		pulse(15);
		cyc(1);
		chk8({7'h00, srq_o}, 8'h00);
		auto = 1'b1;
		pulse(5);
		repeat (20) if (polls === 8'h00) cyc(1);
		auto = 1'b0;
		chk8(status, 8'h60);
		chk8(poll_byte_o, 8'h20);
		chk8({7'h00, srq_o}, 8'h00);
		prior_done_i = 1'b0;
		pulse(17);
		cyc(4);
		chk8({7'h00, stb_valid_o}, 8'h00);
		prior_done_i = 1'b1;
		repeat (10) if (stb_valid_o !== 1'b1) cyc(1);
		chk8({7'h00, stb_valid_o}, 8'h01);
		chk8(stb_data_o, 8'h20);
		chk8(poll_byte_o, 8'h20);
		pulse(15);
	endtask
	task t_mav;
		out_buf_nonempty_i = 1'b1;
		cyc(2);
		chk8(poll_byte_o, 8'h10);
		fetch_mode_i = 1'b1;
		cyc(2);
		chk8(poll_byte_o, 8'h00);
		meas_done_i = 1'b1;
		cyc(2);
		chk8(poll_byte_o, 8'h10);
		out_buf_nonempty_i = 1'b0;
		cyc(2);
		chk8(poll_byte_o, 8'h00);
	endtask
	task t_mask;
		wr(13, 16'h0021);
		wr(14, 16'h1A03);
		chk16(qen_o, 16'h1A03);
		pulse(8);
		chk8(poll_byte_o, 8'h08);
		pulse(16);
		chk16(qev_data_o, 16'h0800);
		pulse(18);
		cyc(1);
		chk8(ese_o, 8'h21);
		chk8(sre_o, 8'h20);
		chk16(qen_o, 16'h0000);
		pulse(15);
		chk8(esr_data_o, 8'h80);
		psc_i = 1'b1;
		pulse(18);
		cyc(1);
		chk8(ese_o, 8'h00);
		chk8(sre_o, 8'h00);
		wr(13, 16'h0021);
		wr(13, 16'h0000);
		chk8(ese_o, 8'h00);
		wr(14, 16'h0003);
		pulse(11);
		chk16(qen_o, 16'h0000);
		wr(14, 16'h0003);
		wr(14, 16'h0000);
		chk16(qen_o, 16'h0000);
		pulse(5);
		pulse(8);
		pulse(10);
		pulse(15);
		chk8(esr_data_o, 8'h00);
		pulse(16);
		chk16(qev_data_o, 16'h0000);
	endtask
	initial
	begin
		repeat (2) @(posedge clock_i);
		#1 rst_i = 1'b0;
		chk8(poll_byte_o, 8'h00);
		t_std();
		t_ques();
		t_srq();
		t_mav();
		t_mask();
		summarize();
	end
	initial
	begin
		#40000;
		mismatches++;
		summarize();
	end
endmodule
